// file: dinput_params.svh
// Constants for the digital input program control block.
// Assumes inclusion by bare name from package and module files.
`ifndef DINPUT_PARAMS_SVH
`define DINPUT_PARAMS_SVH

// ==================================================
// Sizes
`define DIN_NUM_IN 8
`define DIN_IDX_W 3
`define DIN_NUM_DOUT 15
`define DIN_NUM_CHAMBER 8
`define DIN_SEL_W 4
`define DIN_FN_W 12

// ==================================================
// Reset values and timing counts
`define DIN_ARM_CYCLES 2'h3
`define DIN_ARM_RST 2'h0
`define DIN_CMD_RST 8'h00

`endif

// file: dinput_pkg.sv
// Types shared by the digital input program control files.
// Assumes dinput_params.svh is on the include path.
`include "dinput_params.svh"

package dinput_pkg;

    // ==================================================
    // Input function selection, one-hot
    typedef enum logic [`DIN_FN_W-1:0] {
        FN_INACTIVE    = 12'h001,
        FN_RUN         = 12'h002,
        FN_HOLD        = 12'h004,
        FN_CONTINUE    = 12'h008,
        FN_END         = 12'h010,
        FN_WAIT        = 12'h020,
        FN_STEP_BACK   = 12'h040,
        FN_STEP_FWD    = 12'h080,
        FN_CHAMBER_OFF = 12'h100,
        FN_ALL_OFF     = 12'h200,
        FN_EVENT_OFF   = 12'h400,
        FN_EVENT_CTL   = 12'h800
    } dinFunc_t;

    // ==================================================
    // Sequencer status seen by the block
    typedef struct packed {
        logic active;
        logic held;
        logic waiting;
        logic [`DIN_IDX_W-1:0] waitSel;
    } progStatus_t;

    // ==================================================
    // One-cycle commands to the sequencer
    typedef struct packed {
        logic start;
        logic hold;
        logic cont;
        logic stop;
        logic clearEvents;
        logic stepBack;
        logic stepFwd;
        logic waitRelease;
    } progCmd_t;

endpackage

// file: din_conditioner.sv
// Pin synchroniser, edge detector and on-level decode for the digital inputs.
// Assumes pins are asynchronous to core_clk; polarity is static configuration.
`timescale 1ns/1ps
`include "dinput_params.svh"

module din_conditioner #(
    parameter int NUM_IN = `DIN_NUM_IN
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic [NUM_IN-1:0] pin,
    input wire logic [NUM_IN-1:0] polarityRise,
    output logic [NUM_IN-1:0] trig,
    output logic [NUM_IN-1:0] onLvl
);

    // ==================================================
    // Synchroniser and history
    logic [NUM_IN-1:0] syncA_q;
    logic [NUM_IN-1:0] syncB_q;
    logic [NUM_IN-1:0] prev_q;
    logic [1:0] arm_q;
    logic armed;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            syncA_q <= '0;
            syncB_q <= '0;
        end else begin
            syncA_q <= pin;
            syncB_q <= syncA_q;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            prev_q <= '0;
        end else begin
            prev_q <= syncB_q;
        end
    end

    // Edges are held off until history is valid, so a pin high at reset is no edge
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            arm_q <= `DIN_ARM_RST;
        end else if (arm_q != `DIN_ARM_CYCLES) begin
            arm_q <= arm_q + 2'h1;
        end
    end

    assign armed = (arm_q == `DIN_ARM_CYCLES);

    // ==================================================
    // Edge and level decode
    always_comb begin
        for (int i = 0; i < NUM_IN; i++) begin
            trig[i] = armed && (polarityRise[i] ? (syncB_q[i] && !prev_q[i])
                                                : (!syncB_q[i] && prev_q[i]));
            onLvl[i] = armed && (syncB_q[i] == polarityRise[i]);
        end
    end

    property p_trigOnce;
        @(posedge core_clk) disable iff (!rst_b)
        trig[0] |=> !trig[0];
    endproperty
    a_trigOnce: assert property (p_trigOnce) else $error("Input trigger longer than one cycle");

endmodule

// file: din_output_gate.sv
// Registered chamber and digital output gating: kill overrides and input follow.
// Assumes requests and kill levels are on core_clk.
`timescale 1ns/1ps
`include "dinput_params.svh"

module din_output_gate #(
    parameter int NUM_IN = `DIN_NUM_IN,
    parameter int NUM_CH = `DIN_NUM_CHAMBER,
    parameter int NUM_DOUT = `DIN_NUM_DOUT
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic [NUM_CH-1:0] chamberReq,
    input wire logic chamberKill,
    input wire logic [NUM_DOUT-1:0] eventReq,
    input wire logic [NUM_DOUT-1:0] doutIsCustomer,
    input wire logic eventKill,
    input wire logic [NUM_DOUT-1:0][`DIN_SEL_W-1:0] doutFollow,
    input wire logic [NUM_IN-1:0] followLvl,
    output logic [NUM_CH-1:0] chamberOut,
    output logic [NUM_DOUT-1:0] doutOut
);

    // ==================================================
    // Output selection
    function automatic logic followValue(input logic [`DIN_SEL_W-1:0] sel, input logic [NUM_IN-1:0] lvl);
        logic v;
        v = 1'b0;
        for (int k = 0; k < NUM_IN; k++) begin
            if (sel == `DIN_SEL_W'(k + 1)) begin
                v = lvl[k];
            end
        end
        return v;
    endfunction

    logic [NUM_DOUT-1:0] dout_d;

    always_comb begin
        for (int j = 0; j < NUM_DOUT; j++) begin
            if (doutFollow[j] != '0) begin
                dout_d[j] = followValue(doutFollow[j], followLvl);
            end else if (doutIsCustomer[j]) begin
                dout_d[j] = eventReq[j] && !eventKill;
            end else begin
                dout_d[j] = eventReq[j];
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            chamberOut <= '0;
        end else begin
            chamberOut <= chamberKill ? '0 : chamberReq;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            doutOut <= '0;
        end else begin
            doutOut <= dout_d;
        end
    end

    property p_follow0;
        @(posedge core_clk) disable iff (!rst_b)
        (doutFollow[NUM_DOUT-1] == 4'h6) |=> doutOut[NUM_DOUT-1] == $past(followLvl[5]);
    endproperty
    a_follow0: assert property (p_follow0) else $error("Follow output does not track its input");

endmodule

// file: digital_input_program_control.sv
// Digital input program control: eight configurable inputs driving the
// ramp/soak sequencer commands and the chamber and event output overrides.
// Assumes sequencer status and configuration are on core_clk; pins are not.
//
// Functional notes
// - Eight independent inputs, each with own polarity and function.
// - Each input responds to its chosen rising or falling transition.
// - Rising polarity triggers when 24V is applied to the input.
// - Falling polarity triggers when 24V is removed from the input.
// - One-hot function per input; inactive function causes no action.
// - Start edge begins the program only when no program is active.
// - Start edge on a held active program returns it to run.
// - Pause edge holds a running program; otherwise nothing happens.
// - Resume edge returns a held program to run; otherwise nothing.
// - Stop edge ends the program and clears events, only when running; the code also stops a held program.
// - Sequence commands fire once per transition, never from steady levels.
// - Wait-trigger edge releases a step waiting on this input.
// - Wait-trigger edges before the wait state are ignored, not latched.
// - Step moves happen only if held before the input turned on.
// - Chamber-kill forces chamber outputs off while the input is on.
// - All-kill forces chamber and customer event outputs off while on.
// - Event-kill forces customer event outputs off while the input is on.
// - Follow outputs mirror the on state of their assigned input.
// - On level comes from polarity: rising means voltage present.
// - Inputs sharing a function act independently, no arbitration.
// - A follow output stays off unless its input selects follow control.
`timescale 1ns/1ps
`include "dinput_params.svh"

module digital_input_program_control #(
    parameter int NUM_IN = `DIN_NUM_IN,
    parameter int NUM_CH = `DIN_NUM_CHAMBER,
    parameter int NUM_DOUT = `DIN_NUM_DOUT
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic [NUM_IN-1:0] dinPin,
    input wire logic [NUM_IN-1:0] polarityRise,
    input wire dinput_pkg::dinFunc_t [NUM_IN-1:0] funcSel,
    input wire dinput_pkg::progStatus_t progStatus,
    input wire logic [NUM_CH-1:0] chamberReq,
    input wire logic [NUM_DOUT-1:0] eventReq,
    input wire logic [NUM_DOUT-1:0] doutIsCustomer,
    input wire logic [NUM_DOUT-1:0][`DIN_SEL_W-1:0] doutFollow,
    output dinput_pkg::progCmd_t progCmd,
    output logic [NUM_CH-1:0] chamberOut,
    output logic [NUM_DOUT-1:0] doutOut,
    output logic [NUM_IN-1:0] inputOn
);

    // ==================================================
    // Input conditioning
    logic [NUM_IN-1:0] trig;
    logic [NUM_IN-1:0] onLvl;

    din_conditioner #(
        .NUM_IN(NUM_IN)
    ) u_cond (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .pin(dinPin),
        .polarityRise(polarityRise),
        .trig(trig),
        .onLvl(onLvl)
    );

    // ==================================================
    // Function decode
    // Exact compare: an illegal or inactive code matches no function
    function automatic logic anyWith(
        input dinput_pkg::dinFunc_t [NUM_IN-1:0] sel,
        input logic [NUM_IN-1:0] mask,
        input dinput_pkg::dinFunc_t fn
    );
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < NUM_IN; i++) begin
            hit = hit | (mask[i] && (sel[i] == fn));
        end
        return hit;
    endfunction

    logic trigRun;
    logic trigHold;
    logic trigCont;
    logic trigEnd;
    logic trigBack;
    logic trigFwd;
    logic trigWait;
    logic chamberKill;
    logic eventKill;
    logic [NUM_IN-1:0] followLvl;

    assign trigRun = anyWith(funcSel, trig, dinput_pkg::FN_RUN);
    assign trigHold = anyWith(funcSel, trig, dinput_pkg::FN_HOLD);
    assign trigCont = anyWith(funcSel, trig, dinput_pkg::FN_CONTINUE);
    assign trigEnd = anyWith(funcSel, trig, dinput_pkg::FN_END);
    assign trigBack = anyWith(funcSel, trig, dinput_pkg::FN_STEP_BACK);
    assign trigFwd = anyWith(funcSel, trig, dinput_pkg::FN_STEP_FWD);

    // Only the input the waiting step names can release it, and only on its edge
    assign trigWait = progStatus.waiting
        && trig[progStatus.waitSel]
        && (funcSel[progStatus.waitSel] == dinput_pkg::FN_WAIT);

    // Kill overrides are levels, not edges
    assign chamberKill = anyWith(funcSel, onLvl, dinput_pkg::FN_CHAMBER_OFF)
        | anyWith(funcSel, onLvl, dinput_pkg::FN_ALL_OFF);
    assign eventKill = anyWith(funcSel, onLvl, dinput_pkg::FN_EVENT_OFF)
        | anyWith(funcSel, onLvl, dinput_pkg::FN_ALL_OFF);

    always_comb begin
        for (int i = 0; i < NUM_IN; i++) begin
            followLvl[i] = onLvl[i] && (funcSel[i] == dinput_pkg::FN_EVENT_CTL);
        end
    end

    // ==================================================
    // Hold history for step moves
    // A hold arriving in the same cycle as the step edge does not count
    logic heldPrev_q;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            heldPrev_q <= 1'b0;
        end else begin
            heldPrev_q <= progStatus.active && progStatus.held;
        end
    end

    // ==================================================
    // Sequencer commands
    dinput_pkg::progCmd_t cmd_d;
    logic heldNow;

    assign heldNow = progStatus.active && progStatus.held;

    always_comb begin
        cmd_d = `DIN_CMD_RST;
        cmd_d.start = trigRun && !progStatus.active;
        cmd_d.cont = (trigRun || trigCont) && heldNow;
        cmd_d.hold = trigHold && progStatus.active && !progStatus.held;
        cmd_d.stop = trigEnd && progStatus.active;
        cmd_d.clearEvents = trigEnd && progStatus.active;
        cmd_d.stepBack = trigBack && heldPrev_q && heldNow;
        cmd_d.stepFwd = trigFwd && heldPrev_q && heldNow;
        cmd_d.waitRelease = trigWait;
    end

    // Commands come from one-cycle edge pulses, so they are single-shot
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            progCmd <= `DIN_CMD_RST;
        end else begin
            progCmd <= cmd_d;
        end
    end

    // ==================================================
    // Input state readback
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            inputOn <= '0;
        end else begin
            inputOn <= onLvl;
        end
    end

    // ==================================================
    // Output gating
    din_output_gate #(
        .NUM_IN(NUM_IN),
        .NUM_CH(NUM_CH),
        .NUM_DOUT(NUM_DOUT)
    ) u_gate (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .chamberReq(chamberReq),
        .chamberKill(chamberKill),
        .eventReq(eventReq),
        .doutIsCustomer(doutIsCustomer),
        .eventKill(eventKill),
        .doutFollow(doutFollow),
        .followLvl(followLvl),
        .chamberOut(chamberOut),
        .doutOut(doutOut)
    );

    // ==================================================
    // Assertions
    sequence s_runEdgeIdle;
        trigRun && !progStatus.active;
    endsequence

    sequence s_runEdgeHeld;
        trigRun && progStatus.active && progStatus.held;
    endsequence

    sequence s_runEdgeBusy;
        trigRun && !trigCont && progStatus.active && !progStatus.held;
    endsequence

    property p_startIdle;
        @(posedge core_clk) disable iff (!rst_b)
        s_runEdgeIdle |=> progCmd.start && !progCmd.cont;
    endproperty
    a_startIdle: assert property (p_startIdle) else $error("Start edge on idle program gave no start");

    property p_startBusy;
        @(posedge core_clk) disable iff (!rst_b)
        s_runEdgeBusy |=> !progCmd.start && !progCmd.cont;
    endproperty
    a_startBusy: assert property (p_startBusy) else $error("Start edge acted on a running program");

    property p_startHeld;
        @(posedge core_clk) disable iff (!rst_b)
        s_runEdgeHeld |=> progCmd.cont && !progCmd.start;
    endproperty
    a_startHeld: assert property (p_startHeld) else $error("Start edge on held program did not resume");

    property p_holdRun;
        @(posedge core_clk) disable iff (!rst_b)
        trigHold |=> progCmd.hold == $past(progStatus.active && !progStatus.held);
    endproperty
    a_holdRun: assert property (p_holdRun) else $error("Pause edge handled wrongly");

    property p_contHeld;
        @(posedge core_clk) disable iff (!rst_b)
        progCmd.cont |-> $past(progStatus.active && progStatus.held);
    endproperty
    a_contHeld: assert property (p_contHeld) else $error("Resume issued while program not held");

    property p_stopActive;
        @(posedge core_clk) disable iff (!rst_b)
        progCmd.stop |-> progCmd.clearEvents && $past(progStatus.active && trigEnd);
    endproperty
    a_stopActive: assert property (p_stopActive) else $error("Stop issued without running program");

    property p_singleShot;
        @(posedge core_clk) disable iff (!rst_b)
        progCmd.start |=> !progCmd.start [*2];
    endproperty
    a_singleShot: assert property (p_singleShot) else $error("Start command repeated");

    property p_waitGate;
        @(posedge core_clk) disable iff (!rst_b)
        progCmd.waitRelease |-> $past(progStatus.waiting);
    endproperty
    a_waitGate: assert property (p_waitGate) else $error("Wait released outside wait state");

    property p_stepHeld;
        @(posedge core_clk) disable iff (!rst_b)
        (progCmd.stepBack || progCmd.stepFwd) |-> $past(heldPrev_q && heldNow);
    endproperty
    a_stepHeld: assert property (p_stepHeld) else $error("Step move without prior hold");

    property p_chamberKill;
        @(posedge core_clk) disable iff (!rst_b)
        chamberKill |=> chamberOut == '0;
    endproperty
    a_chamberKill: assert property (p_chamberKill) else $error("Chamber outputs not forced off");

    property p_chamberResume;
        @(posedge core_clk) disable iff (!rst_b)
        !chamberKill |=> chamberOut == $past(chamberReq);
    endproperty
    a_chamberResume: assert property (p_chamberResume) else $error("Chamber outputs not released");

    property p_eventKill;
        @(posedge core_clk) disable iff (!rst_b)
        (eventKill && doutIsCustomer[0] && doutFollow[0] == '0) |=> !doutOut[0];
    endproperty
    a_eventKill: assert property (p_eventKill) else $error("Customer event output not forced off");

    sequence s_heldBack;
        heldNow ##1 (heldNow && trigBack);
    endsequence

    sequence s_heldFwd;
        heldNow ##1 (heldNow && trigFwd);
    endsequence

    property p_stepBackGo;
        @(posedge core_clk) disable iff (!rst_b)
        s_heldBack |=> progCmd.stepBack;
    endproperty
    a_stepBackGo: assert property (p_stepBackGo) else $error("Step back refused on held program");

    property p_stepFwdGo;
        @(posedge core_clk) disable iff (!rst_b)
        s_heldFwd |=> progCmd.stepFwd;
    endproperty
    a_stepFwdGo: assert property (p_stepFwdGo) else $error("Step forward refused on held program");

    property p_stepFresh;
        @(posedge core_clk) disable iff (!rst_b)
        (trigBack || trigFwd) && !$past(heldNow) |=> !progCmd.stepBack && !progCmd.stepFwd;
    endproperty
    a_stepFresh: assert property (p_stepFresh) else $error("Step move without earlier hold");

    property p_contGo;
        @(posedge core_clk) disable iff (!rst_b)
        trigCont && heldNow |=> progCmd.cont;
    endproperty
    a_contGo: assert property (p_contGo) else $error("Resume edge on held program gave no resume");

    property p_contIdle;
        @(posedge core_clk) disable iff (!rst_b)
        trigCont && !heldNow |=> !progCmd.cont;
    endproperty
    a_contIdle: assert property (p_contIdle) else $error("Resume edge acted on unheld program");

    property p_stopGo;
        @(posedge core_clk) disable iff (!rst_b)
        trigEnd && progStatus.active |=> progCmd.stop && progCmd.clearEvents;
    endproperty
    a_stopGo: assert property (p_stopGo) else $error("Stop edge on running program gave no stop");

    property p_stopIdle;
        @(posedge core_clk) disable iff (!rst_b)
        trigEnd && !progStatus.active |=> !progCmd.stop && !progCmd.clearEvents;
    endproperty
    a_stopIdle: assert property (p_stopIdle) else $error("Stop edge acted on idle program");

    property p_waitOther;
        @(posedge core_clk) disable iff (!rst_b)
        progStatus.waiting && !trig[progStatus.waitSel] |=> !progCmd.waitRelease;
    endproperty
    a_waitOther: assert property (p_waitOther) else $error("Wait released by another input");

    property p_eventResume;
        @(posedge core_clk) disable iff (!rst_b)
        (!eventKill && doutIsCustomer[0] && doutFollow[0] == '0) |=> doutOut[0] == $past(eventReq[0]);
    endproperty
    a_eventResume: assert property (p_eventResume) else $error("Customer event output not released");

    property p_plainNoKill;
        @(posedge core_clk) disable iff (!rst_b)
        (!doutIsCustomer[8] && doutFollow[8] == '0) |=> doutOut[8] == $past(eventReq[8]);
    endproperty
    a_plainNoKill: assert property (p_plainNoKill) else $error("Plain output does not track request");

    property p_followOff;
        @(posedge core_clk) disable iff (!rst_b)
        (doutFollow[NUM_DOUT-1] == 4'h6 && funcSel[5] != dinput_pkg::FN_EVENT_CTL) |=> !doutOut[NUM_DOUT-1];
    endproperty
    a_followOff: assert property (p_followOff) else $error("Follow output on without follow control");

endmodule

// file: contact_bank.sv
// Model of the external switch, relay or transistor contacts on the eight inputs.
// Assumes the bench opens and closes contacts shortly after a clock edge.
`timescale 1ns/1ps

module contact_bank (
    input wire logic [7:0] closed,
    output logic [7:0] dinPin
);
    // ==================================================
    // Contacts
    // A closed contact applies the supply; an open one leaves the input at common,
    // so an open input never floats to the last driven level
    assign dinPin = closed;
endmodule

// file: testbench.sv
// Self-checking bench for the digital input program control block.
// Assumes dinput_pkg is compiled first and contact_bank models the far side.
`timescale 1ns/1ps

module testbench;
    localparam int NI = 8;
    logic core_clk;
    logic rst_b;
    logic [7:0] closed;
    logic [7:0] dinPin;
    logic [7:0] polarityRise;
    dinput_pkg::dinFunc_t [7:0] funcSel;
    dinput_pkg::progStatus_t progStatus;
    logic [7:0] chamberReq;
    logic [14:0] eventReq;
    logic [14:0] doutIsCustomer;
    logic [14:0][3:0] doutFollow;
    dinput_pkg::progCmd_t progCmd;
    logic [7:0] chamberOut;
    logic [14:0] doutOut;
    logic [7:0] inputOn;
    int errors;
    int numChecks;

    // ==================================================
    // Instances
    contact_bank u_contact_bank (
        .closed(closed),
        .dinPin(dinPin)
    );

    digital_input_program_control u_digital_input_program_control (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .dinPin(dinPin),
        .polarityRise(polarityRise),
        .funcSel(funcSel),
        .progStatus(progStatus),
        .chamberReq(chamberReq),
        .eventReq(eventReq),
        .doutIsCustomer(doutIsCustomer),
        .doutFollow(doutFollow),
        .progCmd(progCmd),
        .chamberOut(chamberOut),
        .doutOut(doutOut),
        .inputOn(inputOn)
    );

    // ==================================================
    // Helpers
    task automatic end_of_test();
        if (errors == 0 && numChecks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        numChecks++;
        if (got !== exp) begin
            errors++;
            $display("ERROR at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask

    // Inputs always move 1 ns after the rising edge
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    // All inputs inactive and at their off level first, so a polarity change never reads as an edge
    task automatic arm(input int idx, input dinput_pkg::dinFunc_t fn, input logic pol);
        for (int i = 0; i < NI; i++) begin
            funcSel[i] = dinput_pkg::FN_INACTIVE;
        end
        polarityRise = {8{pol}};
        closed = pol ? 8'h00 : 8'hff;
        cyc(6);
        funcSel[idx] = fn;
        cyc(1);
    endtask

    // ==================================================
    // Sequencer command scenario: quiet before, one pulse two edges after sampling, quiet after
    task automatic cmd_case(input int idx, input dinput_pkg::dinFunc_t fn, input logic pol,
                            input logic [5:0] st, input logic [7:0] exp);
        arm(idx, fn, pol);
        progStatus = st;
        for (int i = 0; i < 3; i++) begin
            cyc(1);
            chk(progCmd, 8'h00);
        end
        closed[idx] = pol;
        cyc(2);
        chk(progCmd, 8'h00);
        cyc(1);
        chk(progCmd, exp);
        chk(inputOn, 8'h01 << idx);
        for (int i = 0; i < 5; i++) begin
            cyc(1);
            chk(progCmd, 8'h00);
        end
        closed[idx] = ~pol;
        for (int i = 0; i < 4; i++) begin
            cyc(1);
            chk(progCmd, 8'h00);
        end
        progStatus = 6'h00;
    endtask

    // ==================================================
    // Output override scenario: normal, forced while on, normal again after release
    task automatic out_case(input int idx, input dinput_pkg::dinFunc_t fn, input logic pol,
                            input logic [7:0] expCh, input logic [14:0] expDo);
        arm(idx, fn, pol);
        chk(chamberOut, 8'ha5);
        chk(doutOut, 15'h1a5a);
        closed[idx] = pol;
        cyc(2);
        chk(chamberOut, 8'ha5);
        chk(doutOut, 15'h1a5a);
        cyc(1);
        chk(chamberOut, expCh);
        chk(doutOut, expDo);
        closed[idx] = ~pol;
        cyc(3);
        chk(chamberOut, 8'ha5);
        chk(doutOut, 15'h1a5a);
    endtask

    // Two inputs share the chamber kill; releasing one must not release the outputs
    task automatic shared_case();
        arm(6, dinput_pkg::FN_CHAMBER_OFF, 1'b1);
        funcSel[7] = dinput_pkg::FN_CHAMBER_OFF;
        closed[7:6] = 2'h3;
        cyc(3);
        chk(chamberOut, 8'h00);
        closed[6] = 1'b0;
        cyc(3);
        chk(inputOn, 8'h80);
        chk(chamberOut, 8'h00);
        closed[7] = 1'b0;
        cyc(3);
        chk(chamberOut, 8'ha5);
    endtask

    // A wait edge seen before the step waits must not release it later
    task automatic wait_late_case();
        cmd_case(1, dinput_pkg::FN_WAIT, 1'b1, 6'h20, 8'h00);
        progStatus = 6'h29;
        for (int i = 0; i < 4; i++) begin
            cyc(1);
            chk(progCmd, 8'h00);
        end
        progStatus = 6'h00;
    endtask

    // ==================================================
    // Clock and watchdog
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    initial begin
        repeat (20000) @(posedge core_clk);
        errors++;
        end_of_test();
    end

    // ==================================================
    // Main sequence
    initial begin
        errors = 0;
        numChecks = 0;
        rst_b = 1'b0;
        closed = 8'hff;
        polarityRise = 8'hff;
        for (int i = 0; i < NI; i++) begin
            funcSel[i] = dinput_pkg::FN_RUN;
        end
        progStatus = 6'h00;
        chamberReq = 8'ha5;
        eventReq = 15'h5a5a;
        doutIsCustomer = 15'h00ff;
        doutFollow = {15{4'h0}};
        doutFollow[14] = 4'h6;
        cyc(8);
        chk(progCmd, 8'h00);
        chk({chamberOut, doutOut, inputOn}, 32'h0);
        rst_b = 1'b1;
        // Pins already on at reset release must not start the program
        for (int i = 0; i < 10; i++) begin
            cyc(1);
            chk(progCmd, 8'h00);
        end
        cmd_case(0, dinput_pkg::FN_RUN, 1'b1, 6'h00, 8'h80);
        cmd_case(1, dinput_pkg::FN_RUN, 1'b1, 6'h20, 8'h00);
        cmd_case(2, dinput_pkg::FN_RUN, 1'b0, 6'h30, 8'h20);
        cmd_case(3, dinput_pkg::FN_HOLD, 1'b1, 6'h20, 8'h40);
        cmd_case(4, dinput_pkg::FN_HOLD, 1'b0, 6'h00, 8'h00);
        cmd_case(5, dinput_pkg::FN_CONTINUE, 1'b1, 6'h30, 8'h20);
        cmd_case(6, dinput_pkg::FN_CONTINUE, 1'b1, 6'h20, 8'h00);
        cmd_case(7, dinput_pkg::FN_END, 1'b0, 6'h20, 8'h18);
        cmd_case(0, dinput_pkg::FN_END, 1'b1, 6'h00, 8'h00);
        wait_late_case();
        cmd_case(1, dinput_pkg::FN_WAIT, 1'b1, 6'h29, 8'h01);
        cmd_case(1, dinput_pkg::FN_WAIT, 1'b1, 6'h2a, 8'h00);
        cmd_case(2, dinput_pkg::FN_STEP_BACK, 1'b1, 6'h30, 8'h04);
        cmd_case(3, dinput_pkg::FN_STEP_FWD, 1'b0, 6'h30, 8'h02);
        cmd_case(4, dinput_pkg::FN_STEP_FWD, 1'b1, 6'h20, 8'h00);
        cmd_case(5, dinput_pkg::FN_INACTIVE, 1'b1, 6'h00, 8'h00);
        out_case(0, dinput_pkg::FN_CHAMBER_OFF, 1'b1, 8'h00, 15'h1a5a);
        out_case(1, dinput_pkg::FN_ALL_OFF, 1'b0, 8'h00, 15'h1a00);
        out_case(2, dinput_pkg::FN_EVENT_OFF, 1'b1, 8'ha5, 15'h1a00);
        out_case(5, dinput_pkg::FN_EVENT_CTL, 1'b1, 8'ha5, 15'h5a5a);
        out_case(5, dinput_pkg::FN_EVENT_CTL, 1'b0, 8'ha5, 15'h5a5a);
        out_case(4, dinput_pkg::FN_EVENT_CTL, 1'b1, 8'ha5, 15'h1a5a);
        out_case(5, dinput_pkg::FN_HOLD, 1'b1, 8'ha5, 15'h1a5a);
        shared_case();
        end_of_test();
    end
endmodule
